// ---- core/lcr_config_bank.v ----
// Configuration register bank of the graphics LCD controller
`timescale 1ns/10ps
// Operation
// - Bank sits at offset 8000h, memory configuration at base.
// - Groups: system 00h-08h, display 09h-1Bh, drawing 1Ch-1Fh, bpp 20h.
// - Not-applicable bits never affect hardware behaviour.
// - Initialisation command in indirect mode loads registers 00h..07h in order.
// - Writing memory configuration resets timing and turns display off.
// - That write in indirect mode also ends power save.
// - Origin compensation bit 5 zero offsets text one row down.
// - Horizontal pixel scroll shifts text right one to seven pixels.
// - Reserved bit 4 of memory configuration defaults to one.
// - Panel drive bit 3: zero single, one dual panel.
// - Blocks 1-3 start from pairs 0Bh/0Ch, 0Eh/0Fh, 11h/12h, low first.
// - Block 4 start valid only in dual-panel drive.
// - Cursor moves continuously over whole screen in both drives.
// - Character height bit 2: zero eight, one sixteen pixels.
// - Character source bit 0: zero fixed ROM, one user RAM.
`include "lcr_regs.vh"

module lcr_config_bank (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire [15:0] host_addr,
  input  wire        host_wr,
  input  wire        host_rd,
  input  wire [7:0]  host_wdata,
  output reg  [7:0]  host_rdata,
  input  wire        indirect_mode,
  input  wire        init_cmd_start,
  input  wire        init_param_valid,
  input  wire [7:0]  init_param,
  output wire        init_busy,
  output reg         timing_reset,
  output reg         display_on,
  output reg         power_save,
  output reg         origin_comp_row_offset,
  output reg  [2:0]  horizontal_pixel_scroll_cmd,
  output reg         panel_dual,
  output reg         char_height_16,
  output reg         char_source_ram,
  output reg  [15:0] block1_start,
  output reg  [15:0] block2_start,
  output reg  [15:0] block3_start,
  output reg  [15:0] block4_start,
  output reg         block4_valid,
  output reg  [7:0]  block1_line_count,
  output reg  [7:0]  block2_line_count,
  output reg         line_count_error,
  output reg         frame_height_error,
  output reg         cursor_wrap_whole_screen
);

  // ==========================================================
  // Storage
  reg [7:0] regs_r [0:32];
  reg       load_state_r;
  reg [2:0] load_idx_r;
  reg       load_state_nxt;
  reg [2:0] load_idx_nxt;
  integer   i;

  // Index of a bus address inside the bank, or all ones when outside
  function [5:0] bank_index;
    input [15:0] addr;
    reg   [15:0] off;
    begin
      off = addr - `LCR_BANK_BASE;
      if (addr >= `LCR_BANK_BASE && off < {10'h000, `LCR_NUM_REGS})
        bank_index = off[5:0];
      else
        bank_index = 6'h3F;
    end
  endfunction

  wire [5:0] wr_idx  = bank_index(host_addr);
  wire       bus_hit = (wr_idx != 6'h3F);
  wire       bus_wr  = host_wr && bus_hit && !load_state_r;

  // ==========================================================
  // Initialisation command parameter loader
  assign init_busy = load_state_r;

  always @* begin
    load_state_nxt = load_state_r;
    load_idx_nxt   = load_idx_r;
    case (load_state_r)
      `LCR_ST_IDLE: begin
        if (init_cmd_start && indirect_mode) begin
          load_state_nxt = `LCR_ST_LOAD;
          load_idx_nxt   = 3'h0;
        end
      end
      `LCR_ST_LOAD: begin
        if (init_param_valid) begin
          load_idx_nxt = load_idx_r + 3'h1;
          if (load_idx_r == `LCR_LAST_SYSCTL)
            load_state_nxt = `LCR_ST_IDLE;
        end
      end
      default: begin
        load_state_nxt = `LCR_ST_IDLE;
        load_idx_nxt   = 3'h0;
      end
    endcase
  end

  wire       ld_wr  = load_state_r && init_param_valid;
  wire       any_wr = bus_wr || ld_wr;
  wire [5:0] any_idx  = ld_wr ? {3'h0, load_idx_r} : wr_idx;
  wire [7:0] any_data = ld_wr ? init_param : host_wdata;
  wire       memcfg_wr = any_wr && (any_idx == `LCR_MEMORY_CONFIGURATION);

  // ==========================================================
  // Register file
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      load_state_r <= `LCR_ST_IDLE;
      load_idx_r   <= 3'h0;
      for (i = 0; i < 33; i = i + 1)
        regs_r[i] <= `LCR_RST_DEFAULT;
      regs_r[0] <= `LCR_RST_MEMCFG;
    end else begin
      load_state_r <= load_state_nxt;
      load_idx_r   <= load_idx_nxt;
      // All bits stored as written so reads echo them
      if (any_wr)
        regs_r[any_idx] <= any_data;
      // Display-off and power-save side effects of memory configuration write
      if (memcfg_wr && !(any_wr && any_idx == `LCR_DISPLAY_ENABLE))
        regs_r[`LCR_DISPLAY_ENABLE][`LCR_DEN_ENABLE] <= 1'b0;
      if (memcfg_wr && indirect_mode)
        regs_r[`LCR_POWER_SAVE_MODE][`LCR_PSM_ENABLE] <= 1'b0;
    end
  end

  // ==========================================================
  // Read select, one arm per register so unmapped holes read zero
  reg [7:0] rd_mux;

  always @* begin
    rd_mux = 8'h00;
    case (wr_idx)
      `LCR_MEMORY_CONFIGURATION:
        rd_mux = regs_r[`LCR_MEMORY_CONFIGURATION];
      `LCR_HORIZONTAL_CHAR_SIZE:
        rd_mux = regs_r[`LCR_HORIZONTAL_CHAR_SIZE];
      `LCR_VERTICAL_CHAR_SIZE:
        rd_mux = regs_r[`LCR_VERTICAL_CHAR_SIZE];
      `LCR_CHAR_BYTES_PER_ROW:
        rd_mux = regs_r[`LCR_CHAR_BYTES_PER_ROW];
      `LCR_TOTAL_CHAR_BYTES_ROW:
        rd_mux = regs_r[`LCR_TOTAL_CHAR_BYTES_ROW];
      `LCR_FRAME_HEIGHT:
        rd_mux = regs_r[`LCR_FRAME_HEIGHT];
      `LCR_HORIZ_ADDR_RANGE_LO:
        rd_mux = regs_r[`LCR_HORIZ_ADDR_RANGE_LO];
      `LCR_HORIZ_ADDR_RANGE_HI:
        rd_mux = regs_r[`LCR_HORIZ_ADDR_RANGE_HI];
      `LCR_POWER_SAVE_MODE:
        rd_mux = regs_r[`LCR_POWER_SAVE_MODE];
      `LCR_DISPLAY_ENABLE:
        rd_mux = regs_r[`LCR_DISPLAY_ENABLE];
      `LCR_DISPLAY_ATTRIBUTE:
        rd_mux = regs_r[`LCR_DISPLAY_ATTRIBUTE];
      `LCR_BLOCK1_START_LO:
        rd_mux = regs_r[`LCR_BLOCK1_START_LO];
      `LCR_BLOCK1_START_HI:
        rd_mux = regs_r[`LCR_BLOCK1_START_HI];
      `LCR_BLOCK1_SIZE:
        rd_mux = regs_r[`LCR_BLOCK1_SIZE];
      `LCR_BLOCK2_START_LO:
        rd_mux = regs_r[`LCR_BLOCK2_START_LO];
      `LCR_BLOCK2_START_HI:
        rd_mux = regs_r[`LCR_BLOCK2_START_HI];
      `LCR_BLOCK2_SIZE:
        rd_mux = regs_r[`LCR_BLOCK2_SIZE];
      `LCR_BLOCK3_START_LO:
        rd_mux = regs_r[`LCR_BLOCK3_START_LO];
      `LCR_BLOCK3_START_HI:
        rd_mux = regs_r[`LCR_BLOCK3_START_HI];
      `LCR_BLOCK4_START_LO:
        rd_mux = regs_r[`LCR_BLOCK4_START_LO];
      `LCR_BLOCK4_START_HI:
        rd_mux = regs_r[`LCR_BLOCK4_START_HI];
      `LCR_CURSOR_WIDTH:
        rd_mux = regs_r[`LCR_CURSOR_WIDTH];
      `LCR_CURSOR_HEIGHT:
        rd_mux = regs_r[`LCR_CURSOR_HEIGHT];
      `LCR_CURSOR_SHIFT_DIR:
        rd_mux = regs_r[`LCR_CURSOR_SHIFT_DIR];
      `LCR_LAYER_OVERLAY:
        rd_mux = regs_r[`LCR_LAYER_OVERLAY];
      `LCR_CHAR_RAM_START_LO:
        rd_mux = regs_r[`LCR_CHAR_RAM_START_LO];
      `LCR_CHAR_RAM_START_HI:
        rd_mux = regs_r[`LCR_CHAR_RAM_START_HI];
      `LCR_HORIZONTAL_PIXEL_SCROLL:
        rd_mux = regs_r[`LCR_HORIZONTAL_PIXEL_SCROLL];
      `LCR_CURSOR_WRITE_LO:
        rd_mux = regs_r[`LCR_CURSOR_WRITE_LO];
      `LCR_CURSOR_WRITE_HI:
        rd_mux = regs_r[`LCR_CURSOR_WRITE_HI];
      `LCR_CURSOR_READ_LO:
        rd_mux = regs_r[`LCR_CURSOR_READ_LO];
      `LCR_CURSOR_READ_HI:
        rd_mux = regs_r[`LCR_CURSOR_READ_HI];
      `LCR_BITS_PER_PIXEL_SELECT:
        rd_mux = regs_r[`LCR_BITS_PER_PIXEL_SELECT];
      default:
        rd_mux = 8'h00;
    endcase
  end

  // Bus read port, registered; unmapped reads return zero
  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      host_rdata <= 8'h00;
    else if (host_rd)
      host_rdata <= rd_mux;
  end

  // ==========================================================
  // Decoded controls toward display engine
  // Only defined bits are decoded; n/a bits 7..6 never reach logic
  wire [7:0] mc   = regs_r[`LCR_MEMORY_CONFIGURATION];
  wire       dual = mc[`LCR_MC_PANEL_DUAL];
  wire [7:0] fh   = regs_r[`LCR_FRAME_HEIGHT];
  wire [7:0] half = (fh >> 1);  // (fh+1)/2-1 when fh is odd
  wire [8:0] fh_p1 = {1'b0, fh} + 9'h001;
  wire [7:0] dual_lines = fh_p1[8:1] - 8'h01;
  wire [7:0] sl1 = regs_r[`LCR_BLOCK1_SIZE];
  wire [7:0] sl2 = regs_r[`LCR_BLOCK2_SIZE];

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timing_reset                <= 1'b0;
      display_on                  <= 1'b0;
      power_save                  <= 1'b0;
      origin_comp_row_offset      <= 1'b0;
      horizontal_pixel_scroll_cmd <= 3'h0;
      panel_dual                  <= 1'b0;
      char_height_16              <= 1'b0;
      char_source_ram             <= 1'b0;
      block1_start                <= 16'h0000;
      block2_start                <= 16'h0000;
      block3_start                <= 16'h0000;
      block4_start                <= 16'h0000;
      block4_valid                <= 1'b0;
      block1_line_count           <= 8'h00;
      block2_line_count           <= 8'h00;
      line_count_error            <= 1'b0;
      frame_height_error          <= 1'b0;
      cursor_wrap_whole_screen    <= 1'b0;
    end else begin
      // One-cycle pulse restarting the display timing generator
      timing_reset    <= memcfg_wr;
      display_on      <= regs_r[`LCR_DISPLAY_ENABLE][`LCR_DEN_ENABLE]
                         && !memcfg_wr;
      power_save      <= regs_r[`LCR_POWER_SAVE_MODE][`LCR_PSM_ENABLE]
                         && !(memcfg_wr && indirect_mode);
      origin_comp_row_offset <= !mc[`LCR_MC_ORIGIN_COMP];
      horizontal_pixel_scroll_cmd <=
        regs_r[`LCR_HORIZONTAL_PIXEL_SCROLL][`LCR_HSCROLL_MSB:0];
      panel_dual      <= dual;
      char_height_16  <= mc[`LCR_MC_CHAR_HEIGHT];
      char_source_ram <= mc[`LCR_MC_CHAR_SOURCE];
      block1_start <= {regs_r[`LCR_BLOCK1_START_HI],
                       regs_r[`LCR_BLOCK1_START_LO]};
      block2_start <= {regs_r[`LCR_BLOCK2_START_HI],
                       regs_r[`LCR_BLOCK2_START_LO]};
      block3_start <= {regs_r[`LCR_BLOCK3_START_HI],
                       regs_r[`LCR_BLOCK3_START_LO]};
      // Single drive masks block 4 so stale values cannot leak out
      block4_start <= dual ? {regs_r[`LCR_BLOCK4_START_HI],
                              regs_r[`LCR_BLOCK4_START_LO]}
                           : 16'h0000;
      block4_valid <= dual;
      block1_line_count <= sl1;
      block2_line_count <= sl2;
      // Host programming checks, flagged rather than corrected
      line_count_error <= dual
        ? ((sl1 != dual_lines) || (sl2 != dual_lines))
        : ((sl1 > fh) || (sl2 > fh));
      frame_height_error <= dual && !fh[0];
      // Both drive modes scan one continuous cursor space
      cursor_wrap_whole_screen <= 1'b1;
    end
  end

  wire unused_half = |half;

endmodule // lcr_config_bank

// ---- core/lcr_regs.vh ----
// Register offsets, field positions and reset values of the LCD config bank
`ifndef LCR_REGS_VH
`define LCR_REGS_VH

// ==========================================================
// Bank placement and size
`define LCR_BANK_BASE        16'h8000
`define LCR_NUM_REGS         6'h21
`define LCR_LAST_SYSCTL      6'h07
`define LCR_LAST_SYSGRP      6'h08
`define LCR_LAST_DISPGRP     6'h1B
`define LCR_LAST_DRAWGRP     6'h1F

// ==========================================================
// Register indices
`define LCR_MEMORY_CONFIGURATION   6'h00
`define LCR_FRAME_HEIGHT           6'h05
`define LCR_POWER_SAVE_MODE        6'h08
`define LCR_DISPLAY_ENABLE         6'h09
`define LCR_BLOCK1_START_LO        6'h0B
`define LCR_BLOCK1_START_HI        6'h0C
`define LCR_BLOCK1_SIZE            6'h0D
`define LCR_BLOCK2_START_LO        6'h0E
`define LCR_BLOCK2_START_HI        6'h0F
`define LCR_BLOCK2_SIZE            6'h10
`define LCR_BLOCK3_START_LO        6'h11
`define LCR_BLOCK3_START_HI        6'h12
`define LCR_BLOCK4_START_LO        6'h13
`define LCR_BLOCK4_START_HI        6'h14
`define LCR_HORIZONTAL_PIXEL_SCROLL 6'h1B
`define LCR_BITS_PER_PIXEL_SELECT  6'h20
`define LCR_HORIZONTAL_CHAR_SIZE   6'h01
`define LCR_VERTICAL_CHAR_SIZE     6'h02
`define LCR_CHAR_BYTES_PER_ROW     6'h03
`define LCR_TOTAL_CHAR_BYTES_ROW   6'h04
`define LCR_HORIZ_ADDR_RANGE_LO    6'h06
`define LCR_HORIZ_ADDR_RANGE_HI    6'h07
`define LCR_DISPLAY_ATTRIBUTE      6'h0A
`define LCR_CURSOR_WIDTH           6'h15
`define LCR_CURSOR_HEIGHT          6'h16
`define LCR_CURSOR_SHIFT_DIR       6'h17
`define LCR_LAYER_OVERLAY          6'h18
`define LCR_CHAR_RAM_START_LO      6'h19
`define LCR_CHAR_RAM_START_HI      6'h1A
`define LCR_CURSOR_WRITE_LO        6'h1C
`define LCR_CURSOR_WRITE_HI        6'h1D
`define LCR_CURSOR_READ_LO         6'h1E
`define LCR_CURSOR_READ_HI         6'h1F

// ==========================================================
// Memory configuration, power save, display enable and pixel scroll fields
`define LCR_MC_CHAR_SOURCE   0
`define LCR_MC_CHAR_HEIGHT   2
`define LCR_MC_PANEL_DUAL    3
`define LCR_MC_RSVD_ONE      4
`define LCR_MC_ORIGIN_COMP   5
`define LCR_PSM_ENABLE       0
`define LCR_DEN_ENABLE       0
`define LCR_HSCROLL_MSB      2

// ==========================================================
// Reset values
`define LCR_RST_MEMCFG       8'h10
`define LCR_RST_DEFAULT      8'h00

// ==========================================================
// Parameter load sequencer states
`define LCR_ST_IDLE          1'b0
`define LCR_ST_LOAD          1'b1

`endif

// ---- tb/lcr_monitor.sv ----
// Assertion checker for the LCD configuration register bank ports
`timescale 1ns/10ps
module lcr_monitor (
  input logic        sys_clk, rst, host_wr, init_busy, indirect_mode,
  input logic        init_cmd_start, timing_reset, display_on, power_save,
  input logic        origin_comp_row_offset, panel_dual, char_height_16,
  input logic        char_source_ram, block4_valid, cursor_wrap_whole_screen,
  input logic [15:0] host_addr, block1_start, block4_start,
  input logic [7:0]  host_wdata,
  input logic [2:0]  horizontal_pixel_scroll_cmd
);
  // ==========================================================
  // Write decode, data delayed to line up with decoded outputs
  logic [7:0] wd1_r, wd2_r;
  wire mc_wr = host_wr && !init_busy && host_addr == 16'h8000;
  wire hs_wr = host_wr && !init_busy && host_addr == 16'h801B;
  wire b1_wr = host_wr && !init_busy && host_addr == 16'h800B;
  always @(posedge sys_clk) begin
    wd1_r <= host_wdata;
    wd2_r <= wd1_r;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Checks
  AST_MC_PULSE:
    assert property (mc_wr |=> timing_reset ##1 !timing_reset)
    else $error("timing reset pulse wrong");
  AST_MC_DISP_OFF:
    assert property (mc_wr |=> !display_on) else $error("display left on");
  AST_MC_PSAVE:
    assert property (mc_wr && indirect_mode |=> !power_save)
    else $error("power save kept");
  AST_ORIGIN:
    assert property (mc_wr |=> ##1 origin_comp_row_offset == !wd2_r[5])
    else $error("origin offset wrong");
  AST_MC_FIELDS:
    assert property (mc_wr |=> ##1 {panel_dual, char_height_16,
      char_source_ram} == {wd2_r[3], wd2_r[2], wd2_r[0]})
    else $error("memory config fields wrong");
  AST_HSCROLL:
    assert property (hs_wr |=> ##1 horizontal_pixel_scroll_cmd == wd2_r[2:0])
    else $error("pixel scroll wrong");
  AST_BLK1_LO:
    assert property (b1_wr |=> ##1 block1_start[7:0] == wd2_r)
    else $error("block1 low byte wrong");
  AST_BLK4:
    assert property (block4_valid == panel_dual &&
      (panel_dual || block4_start == 16'h0000))
    else $error("block4 start used in single drive");
  AST_CURSOR:
    assert property (!$past(rst) |-> cursor_wrap_whole_screen)
    else $error("cursor range not whole screen");
  AST_INIT_BUSY:
    assert property (init_cmd_start && indirect_mode && !init_busy |=> init_busy)
    else $error("init command not taken");
  COV_MC: cover property (mc_wr && indirect_mode);
  COV_INIT: cover property (init_cmd_start && !init_busy);
  COV_DUAL: cover property (panel_dual && block4_valid);
endmodule // lcr_monitor

// ---- tb/lcr_host.sv ----
// Host processor model driving the register bus and init command
`timescale 1ns/10ps
module lcr_host (
  input  logic        sys_clk,
  input  logic [7:0]  host_rdata,
  output logic [15:0] host_addr = 16'h0000,
  output logic [7:0]  host_wdata = 8'h00,
  output logic [7:0]  init_param = 8'h00,
  output logic        host_wr = 1'b0, host_rd = 1'b0,
  output logic        init_cmd_start = 1'b0, init_param_valid = 1'b0
);
  // ==========================================================
  // Bus tasks; one idle cycle between requests
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    @(posedge sys_clk);
    #1 host_addr = 16'h8000 + idx;
    host_wdata = d;
    host_wr = 1'b1;
    @(posedge sys_clk);
    #1 host_wr = 1'b0;
    host_wdata = ~d;
  endtask
  task automatic rd(input logic [5:0] idx, output logic [7:0] d);
    @(posedge sys_clk);
    #1 host_addr = 16'h8000 + idx;
    host_rd = 1'b1;
    @(posedge sys_clk);
    #1 host_rd = 1'b0;
    d = host_rdata;
  endtask
  task automatic init(input logic [63:0] b);
    @(posedge sys_clk);
    #1 init_cmd_start = 1'b1;
    @(posedge sys_clk);
    #1 init_cmd_start = 1'b0;
    for (int i = 0; i < 8; i++) begin
      init_param = b[8*i +: 8];
      init_param_valid = 1'b1;
      @(posedge sys_clk);
      #1;
    end
    init_param_valid = 1'b0;
  endtask
endmodule // lcr_host

// ---- tb/lcd_config_register_bank_bench.sv ----
// Self-checking bench for the LCD configuration register bank
`timescale 1ns/10ps
module lcd_config_register_bank_bench;
  logic        sys_clk = 1'b0, rst = 1'b1, indirect_mode = 1'b0;
  int          n_mismatch = 0, n_tests = 0, i;
  logic [7:0]  rd_v;
  logic [21:0] rows [9];
  wire  [15:0] host_addr, block1_start;
  wire  [7:0]  host_wdata, host_rdata, init_param;
  wire  [2:0]  horizontal_pixel_scroll_cmd;
  wire         host_wr, host_rd, init_cmd_start, init_param_valid, init_busy;
  wire         display_on, power_save, origin_comp_row_offset, panel_dual;
  wire         char_height_16, char_source_ram, block4_valid;
  wire         line_count_error, frame_height_error;
  wire  [6:0]  mc_vec = {display_on, power_save, origin_comp_row_offset,
    panel_dual, char_height_16, char_source_ram, block4_valid};
  always #10 sys_clk = ~sys_clk;
  lcr_host u_host (.*);
  lcr_config_bank u_lcr_config_bank (.*, .timing_reset(), .block2_start(),
    .block3_start(), .block4_start(), .block1_line_count(),
    .block2_line_count(), .cursor_wrap_whole_screen());
  // ==========================================================
  // Checking and closing
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    u_host.rd(a, rd_v);
    chk("read data", e, rd_v);
  endtask
  task complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    rows = '{{6'h05, 8'h0F, 8'h0F}, {6'h08, 8'h01, 8'h01},
      {6'h09, 8'h01, 8'h01}, {6'h0B, 8'h34, 8'h34}, {6'h0C, 8'h12, 8'h12},
      {6'h0D, 8'h07, 8'h07}, {6'h10, 8'h07, 8'h07}, {6'h1B, 8'h07, 8'h07},
      {6'h1F, 8'h5A, 8'h5A}};
    repeat (20) @(posedge sys_clk);
    #1 rst = 1'b0;
    foreach (rows[k]) begin
      u_host.wr(rows[k][21:16], rows[k][15:8]);
      rdchk(rows[k][21:16], rows[k][7:0]);
    end
    chk("block1_start", 16'h1234, block1_start);
    chk("pixel scroll", 16'h0007, horizontal_pixel_scroll_cmd);
    chk("display on", 16'h0001, display_on);
    chk("single errors", 16'h0000, line_count_error);
    $display("table test done");
    // Dual drive with odd frame height value and matching line counts
    indirect_mode = 1'b1;
    u_host.wr(6'h00, 8'h3D);
    repeat (2) @(posedge sys_clk);
    #1 chk("memcfg outputs", 16'h000F, mc_vec);
    chk("errors", 16'h0000, {line_count_error, frame_height_error});
    rdchk(6'h21, 8'h00);
    $display("memcfg test done");
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 rst = 1'b0;
    rdchk(6'h00, 8'h10);
    chk("origin offset", 16'h0001, origin_comp_row_offset);
    rdchk(6'h05, 8'h00);
    $display("reset test done");
    u_host.init(64'h0706050403020130);
    for (i = 0; i < 20 && init_busy !== 1'b0; i++) @(posedge sys_clk);
    if (i == 20) begin
      n_mismatch++;
      complete_run();
    end
    rdchk(6'h00, 8'h30);
    rdchk(6'h07, 8'h07);
    chk("block4 valid", 16'h0000, block4_valid);
    $display("init test done");
    // Dual drive with even frame height and zero line counts is flagged
    u_host.wr(6'h00, 8'h38);
    u_host.wr(6'h05, 8'h04);
    repeat (2) @(posedge sys_clk);
    #1 chk("bad programming", 16'h0003,
      {line_count_error, frame_height_error});
    $display("bad programming test done");
    complete_run();
  end
endmodule // lcd_config_register_bank_bench

bind lcr_config_bank lcr_monitor u_mon (.*);
